// [logic/dsp_req_xbar_pkg.sv]
// Package: register map, field layout and reset values of the DSP request crossbar
package dsp_req_xbar_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int unsigned NUM_SRC     = 28;
  localparam int unsigned NUM_OUT     = 19;
  localparam int unsigned SEL_W       = 5;
  localparam int unsigned FIELDS_PER  = 6;
  localparam int unsigned NUM_REGS    = 4;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;

  // ==========================================================================
  // Register offsets within the configuration space
  // ==========================================================================
  localparam logic [31:0]       CFG_BASE_ADDR  = 32'hFFFE1000;
  localparam logic [ADDR_W-1:0] OFF_MAP_1_6    = 12'h0D0;
  localparam logic [ADDR_W-1:0] OFF_MAP_7_12   = 12'h0D4;
  localparam logic [ADDR_W-1:0] OFF_MAP_13_18  = 12'h0D8;
  localparam logic [ADDR_W-1:0] OFF_MAP_19     = 12'h0DC;

  // ==========================================================================
  // Field layout and reset values
  // ==========================================================================
  localparam int unsigned         FIELD_LSB0   = 0;
  localparam int unsigned         FIELDS_TOP   = 29;
  localparam logic [DATA_W-1:0]   RST_MAP_1_6   = 32'h0A418820;
  localparam logic [DATA_W-1:0]   RST_MAP_7_12  = 32'h16A4A0E6;
  localparam logic [DATA_W-1:0]   RST_MAP_13_18 = 32'h2307B9AC;
  localparam logic [DATA_W-1:0]   RST_MAP_19    = 32'h00000012;

endpackage : dsp_req_xbar_pkg

// [logic/req_sync3.sv]
// Three-stage synchroniser with agreement filter for one asynchronous request line
`timescale 1ns/1ps
`default_nettype none
module req_sync3
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Asynchronous level in, filtered level out
  input  wire logic din,
  output var  logic dout
);

  logic meta_r;
  logic s2_r;
  logic s3_r;
  logic dout_nxt;

  // ==========================================================================
  // Sync chain: output changes once stage two and three agree
  // ==========================================================================
  assign dout_nxt = (s2_r == s3_r) ? s2_r : dout;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      s2_r   <= meta_r;
      s3_r   <= s2_r;
      dout   <= dout_nxt;
    end
  end

endmodule : req_sync3
`default_nettype wire

// [logic/req_select_mux.sv]
// One output lane of the crossbar: picks one of the synchronised sources, registered
`timescale 1ns/1ps
`default_nettype none
module req_select_mux
#(
  parameter int unsigned NUM_SRC = 28,
  parameter int unsigned SEL_W   = 5
)
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  // Sources and selection
  input  wire logic [NUM_SRC-1:0] src,
  input  wire logic [SEL_W-1:0]   sel,
  // Selected level
  output var  logic               req_out
);

  logic picked;

  // Zero-based select; out-of-range codes give an idle line
  assign picked = (32'(sel) < NUM_SRC) ? src[sel] : 1'b0;

  // Register the selected level
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      req_out <= 1'b0;
    else
      req_out <= picked;
  end

endmodule : req_select_mux
`default_nettype wire

// [logic/dsp_dma_request_crossbar.sv]
// Top: DSP DMA request crossbar with its four mapping registers
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - Any of 28 sources to each of 19 outputs
// - Five-bit field, value n selects source n+1
// - Register 0xD0 holds outputs 1 to 6
// - Register 0xD4 holds outputs 7 to 12
// - Register 0xD8 holds outputs 13 to 18
// - Register 0xDC holds output 19 only
// - Reset maps output k to source k
// - All bits read/write, reserved reset zero
// - Registers sit in configuration space offsets
// - Reset mapping matches legacy request numbering
module dsp_dma_request_crossbar
#(
  parameter int unsigned NUM_SRC = dsp_req_xbar_pkg::NUM_SRC,
  parameter int unsigned NUM_OUT = dsp_req_xbar_pkg::NUM_OUT
)
(
  // Clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 arst_n,
  // Register port
  input  wire logic [dsp_req_xbar_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [dsp_req_xbar_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output var  logic [dsp_req_xbar_pkg::DATA_W-1:0]  reg_rdata,
  // Peripheral request sources, asynchronous levels
  input  wire logic [NUM_SRC-1:0]                   periph_req,
  // Requests toward the DSP DMA controller
  output var  logic [NUM_OUT-1:0]                   dsp_dma_req
);

  localparam int unsigned SEL_W  = dsp_req_xbar_pkg::SEL_W;
  localparam int unsigned DATA_W = dsp_req_xbar_pkg::DATA_W;
  localparam int unsigned FPR    = dsp_req_xbar_pkg::FIELDS_PER;

  // ==========================================================================
  // Mapping registers
  // ==========================================================================
  logic [DATA_W-1:0] map_a_r;
  logic [DATA_W-1:0] map_b_r;
  logic [DATA_W-1:0] map_c_r;
  logic [DATA_W-1:0] map_d_r;
  logic [DATA_W-1:0] reg_rdata_nxt;
  logic              hit_a;
  logic              hit_b;
  logic              hit_c;
  logic              hit_d;

  // Address decode of the four words
  assign hit_a = (reg_addr == dsp_req_xbar_pkg::OFF_MAP_1_6);
  assign hit_b = (reg_addr == dsp_req_xbar_pkg::OFF_MAP_7_12);
  assign hit_c = (reg_addr == dsp_req_xbar_pkg::OFF_MAP_13_18);
  assign hit_d = (reg_addr == dsp_req_xbar_pkg::OFF_MAP_19);

  // Full-word writes, reserved bits included; reset gives identity map
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      map_a_r <= dsp_req_xbar_pkg::RST_MAP_1_6;
      map_b_r <= dsp_req_xbar_pkg::RST_MAP_7_12;
      map_c_r <= dsp_req_xbar_pkg::RST_MAP_13_18;
      map_d_r <= dsp_req_xbar_pkg::RST_MAP_19;
    end
    else if (reg_wr)
    begin
      if (hit_a)
        map_a_r <= reg_wdata;
      if (hit_b)
        map_b_r <= reg_wdata;
      if (hit_c)
        map_c_r <= reg_wdata;
      if (hit_d)
        map_d_r <= reg_wdata;
    end
  end

  // Read mux; unmapped addresses read zero
  assign reg_rdata_nxt = hit_a ? map_a_r :
                         hit_b ? map_b_r :
                         hit_c ? map_c_r :
                         hit_d ? map_d_r : '0;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= '0;
    else if (reg_rd)
      reg_rdata <= reg_rdata_nxt;
    else
      reg_rdata <= '0;
  end

  // ==========================================================================
  // Field extraction
  // ==========================================================================
  logic [4*DATA_W-1:0]      map_flat;
  logic [NUM_OUT*SEL_W-1:0] sel_flat;

  // Field k of the whole map: six per word, bits 29:0 used
  function automatic logic [SEL_W-1:0] field_of(input logic [4*DATA_W-1:0] m, input int unsigned k);
    int unsigned w;
    int unsigned f;
    w = k / FPR;
    f = k % FPR;
    field_of = m[w*DATA_W + f*SEL_W +: SEL_W];
  endfunction : field_of

  assign map_flat = {map_d_r, map_c_r, map_b_r, map_a_r};

  // ==========================================================================
  // Source synchronisers and output lanes
  // ==========================================================================
  logic [NUM_SRC-1:0] src_sync;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_sync
      req_sync3 u_sync
      (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .din     (periph_req[gi]),
        .dout    (src_sync[gi])
      );
    end

    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_lane
      assign sel_flat[gi*SEL_W +: SEL_W] = field_of(map_flat, gi);
      // Independent select per output; registered select path
      req_select_mux
      #(
        .NUM_SRC (NUM_SRC),
        .SEL_W   (SEL_W)
      )
      u_lane
      (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .src     (src_sync),
        .sel     (sel_flat[gi*SEL_W +: SEL_W]),  // out-of-range gives idle
        .req_out (dsp_dma_req[gi])
      );
    end
  endgenerate

endmodule : dsp_dma_request_crossbar
`default_nettype wire

// [test/dsp_dma_request_crossbar_chk.sv]
// Checker: port-level properties of the DSP request crossbar
`timescale 1ns/1ps
`default_nettype none
module dsp_dma_request_crossbar_chk
#(
  parameter int unsigned NUM_SRC = 28,
  parameter int unsigned NUM_OUT = 19
)
(
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               arst_n,
  // Register port
  input wire logic [11:0]        reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  // Request lines
  input wire logic [NUM_SRC-1:0] periph_req,
  input wire logic [NUM_OUT-1:0] dsp_dma_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ====
  // Decode and properties
  // Any of the four mapped words
  wire logic hit = reg_addr[11:4] == 8'h0D && reg_addr[1:0] == 2'h0;
  property p_wr_rd; reg_wr && hit ##1 reg_rd && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2); endproperty
  property p_unmap; reg_rd && !hit |=> reg_rdata == 32'h0; endproperty
  property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  // Select stored at the write edge, lane register follows one edge later
  property p_sel_a; $stable(periph_req)[*6] ##0 (reg_wr && reg_addr == 12'h0D0 && reg_wdata[4:0] < 5'd28)
    |-> ##2 (periph_req != $past(periph_req, 2) || dsp_dma_req[0] == periph_req[$past(reg_wdata[4:0], 2)]);
  endproperty
  property p_sel_c; $stable(periph_req)[*6] ##0 (reg_wr && reg_addr == 12'h0D8 && reg_wdata[29:25] < 5'd28)
    |-> ##2 (periph_req != $past(periph_req, 2) || dsp_dma_req[17] == periph_req[$past(reg_wdata[29:25], 2)]);
  endproperty
  property p_sel_d; $stable(periph_req)[*6] ##0 (reg_wr && reg_addr == 12'h0DC && reg_wdata[4:0] < 5'd28)
    |-> ##2 (periph_req != $past(periph_req, 2) || dsp_dma_req[18] == periph_req[$past(reg_wdata[4:0], 2)]);
  endproperty
  property p_low; (periph_req == '0)[*8] |-> dsp_dma_req == '0; endproperty
  property p_hold; ($stable(periph_req) && !reg_wr)[*8] |-> $stable(dsp_dma_req); endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("readback differs");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_idle: assert property (p_idle) else $error("read data outside slot");
  a_sel_a: assert property (p_sel_a) else $error("output 1 source wrong");
  a_sel_c: assert property (p_sel_c) else $error("output 18 source wrong");
  a_sel_d: assert property (p_sel_d) else $error("output 19 source wrong");
  a_low: assert property (p_low) else $error("output without source");
  a_hold: assert property (p_hold) else $error("output moved unprompted");
  c_wr_rd: cover property (p_wr_rd);
  c_unmap: cover property (p_unmap);
  c_sel_d: cover property (p_sel_d);
endmodule : dsp_dma_request_crossbar_chk
bind dsp_dma_request_crossbar dsp_dma_request_crossbar_chk #(.NUM_SRC(NUM_SRC), .NUM_OUT(NUM_OUT)) i_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req), .dsp_dma_req(dsp_dma_req));
`default_nettype wire

// [test/dsp_dma_req_sink.sv]
// Partner: DSP DMA controller request inputs, latching the levels it sees
`timescale 1ns/1ps
`default_nettype none
module dsp_dma_req_sink
#(
  parameter int unsigned NUM_OUT = 19
)
(
  // Clock, reset and request levels
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  input  wire logic [NUM_OUT-1:0] req,
  output var  logic [NUM_OUT-1:0] seen_r
);
  // Request inputs are sampled each cycle
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) seen_r <= '0;
    else seen_r <= req;
endmodule : dsp_dma_req_sink
`default_nettype wire

// [test/dsp_dma_request_crossbar_bench.sv]
// Bench: register and routing checks for the DSP request crossbar
`timescale 1ns/1ps
`default_nettype none
module dsp_dma_request_crossbar_bench;
  logic        sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [27:0] periph_req = '0;
  logic [18:0] dsp_dma_req, seen;
  int          mismatches = 0, compares = 0;
  always #50 sys_clk = ~sys_clk;
  dsp_dma_request_crossbar i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req), .dsp_dma_req(dsp_dma_req));
  dsp_dma_req_sink i_sink (.sys_clk(sys_clk), .arst_n(arst_n), .req(dsp_dma_req), .seen_r(seen));
  // ====
  // Access tasks and expectations
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      reg_wr <= 0;
      reg_rd <= 0;
    end
  endtask : idle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 0;
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_wr <= 0;
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask : rd
  // Field of output k: reset k, else reversed, last output on value 0
  function automatic logic [4:0] sel(input int k, input bit rst);
    return rst ? 5'(k) : (k == 18 ? 5'h00 : 5'(27 - k));
  endfunction : sel
  function automatic logic [31:0] map_word(input int r, input bit rst);
    logic [31:0] w;
    w = rst ? 32'h0 : (r == 3 ? 32'hFFFFFFE0 : 32'hC0000000);
    for (int i = 0; i < 6; i++)
      if (r * 6 + i < 19) w[i*5+:5] = sel(r * 6 + i, rst);
    return w;
  endfunction : map_word
  task automatic scan(input bit rst);
    logic [18:0] e;
    for (int j = 0; j < 28; j++)
    begin
      for (int k = 0; k < 19; k++) e[k] = sel(k, rst) == 5'(j);
      @(posedge sys_clk);
      periph_req <= 28'h1 << j;
      idle(8);
      chk("dsp_dma_req", 32'(e), 32'(seen));
    end
  endtask : scan
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // ====
  // Main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    arst_n <= 1;
    idle(10);
    for (int r = 0; r < 4; r++) rd(12'h0D0 + 12'(4 * r), map_word(r, 1));
    scan(1);
    for (int r = 0; r < 4; r++)
    begin
      wr(12'h0D0 + 12'(4 * r), map_word(r, 0));
      rd(12'h0D0 + 12'(4 * r), map_word(r, 0));
    end
    rd(12'h0E0, 32'h0);
    wr(12'h0E0, 32'hFFFFFFFF);
    rd(12'h0DC, map_word(3, 0));
    scan(0);
    print_verdict();
  end
endmodule : dsp_dma_request_crossbar_bench
`default_nettype wire
